// ### uap_baud_gen.sv
// Baud divider: one tick per divisor count of the reference clock.
// Assumes divisor and load come from the register path on ref_clk.
`timescale 1ns/1ps
module uap_baud_gen
   import uap_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Divider link
   uap_baud_if.gen bif
);

   typedef struct packed {
      logic [15:0] cnt;
      logic tick;
   } uap_baud_state_t;

   uap_baud_state_t s_reg, s_next;

   always_comb begin
      s_next = s_reg;
      s_next.tick = 1'b0;
      if (bif.load) begin
         s_next.cnt = bif.divisor;
      end else if (s_reg.cnt <= 16'h0001) begin
         // Divisor zero behaves as one rather than stalling
         s_next.cnt = bif.divisor;
         s_next.tick = 1'b1;
      end else begin
         s_next.cnt = s_reg.cnt - 16'h0001;
      end
      if (!rst_b) begin
         s_next = '0;
      end
   end

   always_ff @(posedge ref_clk) begin
      s_reg <= s_next;
   end

   assign bif.tick = s_reg.tick;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   AST_BAUD_LOAD: assert property (bif.load |=> s_reg.cnt == $past(bif.divisor))
      else $error("baud counter not reloaded on divisor write");
   AST_BAUD_TICK: assert property ((s_reg.cnt == 16'h0003 && !bif.load &&
      bif.divisor > 16'h0002) ##1 !bif.load ##1 !bif.load |=> bif.tick)
      else $error("baud tick missing at end of count");

endmodule // uap_baud_gen

// ### uap_baud_if.sv
// Link between the register path and the baud divider.
// Assumes both ends share ref_clk.
`timescale 1ns/1ps
interface uap_baud_if;
   logic [15:0] divisor;
   logic load;
   logic tick;
   modport gen (input divisor, input load, output tick);
   modport user (output divisor, output load, input tick);
endinterface

// ### uap_line_peer.sv
// Serial peer on the far side of the receive pin.
// Assumes the bench calls send_char; idle line is high.
`timescale 1ns/1ps
module uap_line_peer (
   // Serial pins toward the block
   output logic rx_clk_in,
   output logic serial_in
);
   // Free 16x clock, phase unrelated to ref_clk
   initial begin
      rx_clk_in = 1'b0;
      serial_in = 1'b1;
      forever #20 rx_clk_in = ~rx_clk_in;
   end

   // One 8N1 frame, LSB first, 16 clocks per bit
   task automatic send_char(input logic [7:0] d);
      logic [9:0] f;
      f = {1'b1, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(negedge rx_clk_in);
         serial_in = f[i];
         repeat (15) @(negedge rx_clk_in);
      end
   endtask
endmodule // uap_line_peer

// ### uap_pkg.sv
// Constants, register map and types of the serial transmit/receive path.
// Assumes one 200 MHz clock and an 8-bit register port with 3 address bits.
package uap_pkg;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [2:0] OFS_DATA = 3'h0;   // rx_buffer / tx_holding
   localparam logic [2:0] OFS_IEN = 3'h1;
   localparam logic [2:0] OFS_FCTL = 3'h2;
   localparam logic [2:0] OFS_LCTL = 3'h3;
   localparam logic [2:0] OFS_DIVL = 3'h4;
   localparam logic [2:0] OFS_DIVH = 3'h5;
   localparam logic [2:0] OFS_STAT = 3'h6;
   localparam logic [2:0] OFS_SCR = 3'h7;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int IEN_RX = 0;
   localparam int IEN_TX = 1;
   localparam int FC_EN = 0;
   localparam int FC_RXCLR = 1;
   localparam int FC_TXCLR = 2;
   localparam int FC_TRIG = 6;
   localparam int LC_STOP = 2;
   localparam int LC_PEN = 3;
   localparam int LC_EVEN = 4;

   // ---------------------------------------------------------------
   // Reset values and counts
   // ---------------------------------------------------------------
   localparam logic [7:0] LCTL_RESET = 8'h03;   // 8 data bits, 1 stop
   localparam logic [4:0] FIFO_DEPTH = 5'h10;
   localparam logic [4:0] CHAR_DEPTH = 5'h01;
   localparam logic [3:0] RX_MID = 4'h7;        // Start bit centre
   localparam logic [3:0] RX_LAST = 4'hF;       // 16 samples per bit
   localparam logic [4:0] TX_BIT_END = 5'h0F;
   localparam logic [4:0] TX_STOP1 = 5'h0F;
   localparam logic [4:0] TX_STOP15 = 5'h17;
   localparam logic [4:0] TX_STOP2 = 5'h1F;

   // ---------------------------------------------------------------
   // State types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP}
      uap_rx_state_t;
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP}
      uap_tx_state_t;

   // Index of the last data bit for the programmed character length
   function automatic logic [2:0] char_last(input logic [7:0] lc);
      return {1'b1, lc[1:0]};
   endfunction

   // Parity bit over the valid data bits
   function automatic logic par_bit(input logic [7:0] d,
                                    input logic [7:0] lc);
      logic [7:0] m;
      m = d & (8'h00FF >> (3'h7 - char_last(lc)));
      return lc[LC_EVEN] ? ^m : ~^m;
   endfunction

endpackage

// ### uap_top.sv
// Serial transmit and receive data path with register port.
// Assumes a synchronous register master on ref_clk; rx_clk_in and
// serial_in are asynchronous pins.
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module uap_top
   import uap_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Serial pins
   input wire logic rx_clk_in,
   input wire logic serial_in,
   output logic serial_out,
   output logic baud_tick_out,
   output logic irq_out
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [15:0][7:0] rx_mem;
      logic [3:0] rx_wp;
      logic [3:0] rx_rp;
      logic [4:0] rx_cnt;
      logic [15:0][7:0] tx_mem;
      logic [3:0] tx_wp;
      logic [3:0] tx_rp;
      logic [4:0] tx_cnt;
      logic [7:0] ien;
      logic [7:0] lctl;
      logic [7:0] scratch;
      logic [7:0] div_lo;
      logic [7:0] div_hi;
      logic div_load;
      logic fifo_en;
      logic [1:0] rx_trig;
      logic [2:0] rclk_sync;
      logic [2:0] sin_sync;
      logic rclk_lvl;
      logic sin_lvl;
      uap_rx_state_t rx_st;
      logic [3:0] rx_tick;
      logic [2:0] rx_bit;
      logic [7:0] rx_shift_reg;
      logic rx_par;
      logic ovr_err;
      logic par_err;
      logic frm_err;
      uap_tx_state_t tx_st;
      logic [4:0] tx_tick;
      logic [2:0] tx_bit;
      logic [7:0] tx_shift_reg;
      logic tx_par;
      logic serial_out;
      logic baud_tick_out;
      logic irq_out;
      logic [7:0] rdata;
   } uap_state_t;

   uap_state_t s_reg, s_next;
   uap_baud_if bif ();

   uap_baud_gen u_baud (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .bif(bif)
   );

   assign bif.divisor = {s_reg.div_hi, s_reg.div_lo};
   assign bif.load = s_reg.div_load;

   logic rx_step;
   logic rx_push;
   logic [4:0] cap;
   logic [4:0] trig_lvl;
   logic [7:0] rx_char;
   logic [4:0] stop_end;
   logic rd_data;
   logic wr_data;

   always_comb begin
      s_next = s_reg;
      s_next.div_load = 1'b0;
      s_next.rdata = 8'h00;
      s_next.baud_tick_out = bif.tick;
      rd_data = reg_rd && reg_addr == OFS_DATA;
      wr_data = reg_wr && reg_addr == OFS_DATA;
      cap = s_reg.fifo_en ? FIFO_DEPTH : CHAR_DEPTH;
      case (s_reg.rx_trig)
         2'h0: trig_lvl = 5'h01;
         2'h1: trig_lvl = 5'h04;
         2'h2: trig_lvl = 5'h08;
         default: trig_lvl = 5'h0E;
      endcase
      rx_char = s_reg.rx_shift_reg >> (3'h7 - char_last(s_reg.lctl));
      if (!s_reg.lctl[LC_STOP]) begin
         stop_end = TX_STOP1;
      end else if (s_reg.lctl[1:0] == 2'h0) begin
         stop_end = TX_STOP15;
      end else begin
         stop_end = TX_STOP2;
      end

      // ------------------------------------------------------------
      // Pin synchronisers: a level counts once stages 2 and 3 agree
      // ------------------------------------------------------------
      s_next.rclk_sync = {s_reg.rclk_sync[1:0], rx_clk_in};
      s_next.sin_sync = {s_reg.sin_sync[1:0], serial_in};
      if (s_reg.rclk_sync[1] == s_reg.rclk_sync[2]) begin
         s_next.rclk_lvl = s_reg.rclk_sync[2];
      end
      if (s_reg.sin_sync[1] == s_reg.sin_sync[2]) begin
         s_next.sin_lvl = s_reg.sin_sync[2];
      end
      rx_step = (s_reg.rclk_sync[1] == s_reg.rclk_sync[2]) &&
                s_reg.rclk_sync[2] && !s_reg.rclk_lvl;

      // ------------------------------------------------------------
      // Receiver
      // ------------------------------------------------------------
      rx_push = 1'b0;
      if (rx_step) begin
         s_next.rx_tick = s_reg.rx_tick + 4'h1;
         case (s_reg.rx_st)
            RX_IDLE: begin
               s_next.rx_tick = 4'h0;
               if (!s_reg.sin_lvl) begin
                  s_next.rx_st = RX_START;
               end
            end
            RX_START: begin
               if (s_reg.rx_tick == RX_MID) begin
                  // A start bit gone high by its centre is noise
                  s_next.rx_st = s_reg.sin_lvl ? RX_IDLE : RX_DATA;
                  s_next.rx_tick = 4'h0;
                  s_next.rx_bit = 3'h0;
               end
            end
            RX_DATA: begin
               if (s_reg.rx_tick == RX_LAST) begin
                  s_next.rx_shift_reg = {s_reg.sin_lvl,
                                         s_reg.rx_shift_reg[7:1]};
                  s_next.rx_bit = s_reg.rx_bit + 3'h1;
                  if (s_reg.rx_bit == char_last(s_reg.lctl)) begin
                     s_next.rx_st = s_reg.lctl[LC_PEN] ? RX_PAR : RX_STOP;
                  end
               end
            end
            RX_PAR: begin
               if (s_reg.rx_tick == RX_LAST) begin
                  s_next.rx_par = s_reg.sin_lvl;
                  s_next.rx_st = RX_STOP;
               end
            end
            RX_STOP: begin
               if (s_reg.rx_tick == RX_LAST) begin
                  rx_push = 1'b1;
                  s_next.rx_st = RX_IDLE;
               end
            end
            default: s_next.rx_st = RX_IDLE;
         endcase
      end

      // ------------------------------------------------------------
      // Receive buffer
      // ------------------------------------------------------------
      if (rd_data && s_reg.rx_cnt != 5'h00) begin
         s_next.rx_rp = s_reg.rx_rp + 4'h1;
         s_next.rx_cnt = s_next.rx_cnt - 5'h01;
      end
      if (rx_push) begin
         // Frame error and parity error are set further below, after the status-read clear,
         // so a new event wins over a status read
         if (s_reg.rx_cnt < cap || (rd_data && s_reg.rx_cnt != 5'h00)) begin
            s_next.rx_mem[s_reg.rx_wp] = rx_char;
            s_next.rx_wp = s_reg.rx_wp + 4'h1;
            s_next.rx_cnt = s_next.rx_cnt + 5'h01;
         end
      end

      // ------------------------------------------------------------
      // Transmitter, stepped by the baud tick
      // ------------------------------------------------------------
      if (bif.tick) begin
         s_next.tx_tick = s_reg.tx_tick + 5'h01;
         case (s_reg.tx_st)
            TX_IDLE: begin
               s_next.tx_tick = 5'h00;
               if (s_reg.tx_cnt != 5'h00) begin
                  s_next.tx_shift_reg = s_reg.tx_mem[s_reg.tx_rp];
                  s_next.tx_par = par_bit(s_reg.tx_mem[s_reg.tx_rp],
                                          s_reg.lctl);
                  s_next.tx_rp = s_reg.tx_rp + 4'h1;
                  s_next.tx_cnt = s_reg.tx_cnt - 5'h01;
                  s_next.tx_st = TX_START;
               end
            end
            TX_START: begin
               if (s_reg.tx_tick == TX_BIT_END) begin
                  s_next.tx_tick = 5'h00;
                  s_next.tx_bit = 3'h0;
                  s_next.tx_st = TX_DATA;
               end
            end
            TX_DATA: begin
               if (s_reg.tx_tick == TX_BIT_END) begin
                  s_next.tx_tick = 5'h00;
                  s_next.tx_shift_reg = s_reg.tx_shift_reg >> 1;
                  s_next.tx_bit = s_reg.tx_bit + 3'h1;
                  if (s_reg.tx_bit == char_last(s_reg.lctl)) begin
                     s_next.tx_st = s_reg.lctl[LC_PEN] ? TX_PAR : TX_STOP;
                  end
               end
            end
            TX_PAR: begin
               if (s_reg.tx_tick == TX_BIT_END) begin
                  s_next.tx_tick = 5'h00;
                  s_next.tx_st = TX_STOP;
               end
            end
            TX_STOP: begin
               if (s_reg.tx_tick == stop_end) begin
                  s_next.tx_st = TX_IDLE;
               end
            end
            default: s_next.tx_st = TX_IDLE;
         endcase
      end
      if (wr_data && s_next.tx_cnt < cap) begin
         s_next.tx_mem[s_reg.tx_wp] = reg_wdata;
         s_next.tx_wp = s_reg.tx_wp + 4'h1;
         s_next.tx_cnt = s_next.tx_cnt + 5'h01;
      end

      // ------------------------------------------------------------
      // Register port
      // ------------------------------------------------------------
      if (reg_rd) begin
         case (reg_addr)
            OFS_DATA: s_next.rdata = s_reg.rx_mem[s_reg.rx_rp];
            OFS_IEN: s_next.rdata = s_reg.ien;
            OFS_FCTL: s_next.rdata = {s_reg.rx_trig, 5'h00, s_reg.fifo_en};
            OFS_LCTL: s_next.rdata = s_reg.lctl;
            OFS_DIVL: s_next.rdata = s_reg.div_lo;
            OFS_DIVH: s_next.rdata = s_reg.div_hi;
            OFS_STAT: begin
               s_next.rdata = {2'h0, s_reg.frm_err, s_reg.par_err,
                  s_reg.ovr_err,
                  s_reg.tx_cnt == 5'h00 && s_reg.tx_st == TX_IDLE,
                  s_reg.tx_cnt == 5'h00, s_reg.rx_cnt != 5'h00};
               s_next.ovr_err = 1'b0;
               s_next.par_err = 1'b0;
               s_next.frm_err = 1'b0;
            end
            default: s_next.rdata = s_reg.scratch;
         endcase
      end
      if (rx_push) begin
         if (s_reg.rx_cnt >= cap && !(rd_data && s_reg.rx_cnt != 5'h00)) begin
            s_next.ovr_err = 1'b1;
         end
         if (!s_reg.sin_lvl) begin
            s_next.frm_err = 1'b1;
         end
         if (s_reg.lctl[LC_PEN] &&
             s_reg.rx_par != par_bit(rx_char, s_reg.lctl)) begin
            s_next.par_err = 1'b1;
         end
      end
      if (reg_wr) begin
         case (reg_addr)
            OFS_IEN: s_next.ien = reg_wdata;
            OFS_FCTL: begin
               s_next.fifo_en = reg_wdata[FC_EN];
               s_next.rx_trig = reg_wdata[FC_TRIG +: 2];
               // Switching mode flushes both buffers
               if (reg_wdata[FC_RXCLR] || reg_wdata[FC_EN] != s_reg.fifo_en)
               begin
                  s_next.rx_wp = 4'h0;
                  s_next.rx_rp = 4'h0;
                  s_next.rx_cnt = 5'h00;
               end
               if (reg_wdata[FC_TXCLR] || reg_wdata[FC_EN] != s_reg.fifo_en)
               begin
                  s_next.tx_wp = 4'h0;
                  s_next.tx_rp = 4'h0;
                  s_next.tx_cnt = 5'h00;
               end
            end
            OFS_LCTL: s_next.lctl = reg_wdata;
            OFS_DIVL: begin
               s_next.div_lo = reg_wdata;
               s_next.div_load = 1'b1;
            end
            OFS_DIVH: begin
               s_next.div_hi = reg_wdata;
               s_next.div_load = 1'b1;
            end
            OFS_SCR: s_next.scratch = reg_wdata;
            default: ;
         endcase
      end

      // ------------------------------------------------------------
      // Outputs
      // ------------------------------------------------------------
      case (s_next.tx_st)
         TX_START: s_next.serial_out = 1'b0;
         TX_DATA: s_next.serial_out = s_next.tx_shift_reg[0];
         TX_PAR: s_next.serial_out = s_next.tx_par;
         default: s_next.serial_out = 1'b1;
      endcase
      s_next.irq_out = (s_reg.ien[IEN_RX] &&
         (s_reg.fifo_en ? s_reg.rx_cnt >= trig_lvl :
          s_reg.rx_cnt != 5'h00)) ||
         (s_reg.ien[IEN_TX] && s_reg.tx_cnt == 5'h00);

      if (!rst_b) begin
         s_next = '0;
         s_next.lctl = LCTL_RESET;
         s_next.serial_out = 1'b1;
         s_next.rclk_sync = 3'h0;
         // Start from the idle high line so release makes no false start
         s_next.sin_sync = 3'h7;
         s_next.sin_lvl = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      s_reg <= s_next;
   end

   assign reg_rdata = s_reg.rdata;
   assign serial_out = s_reg.serial_out;
   assign baud_tick_out = s_reg.baud_tick_out;
   assign irq_out = s_reg.irq_out;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   AST_RX_DEPTH: assert property (s_reg.rx_cnt <= FIFO_DEPTH)
      else $error("receive buffer over 16 entries");
   AST_RX_CLOCK: assert property (!rx_step |=>
      s_reg.rx_tick == $past(s_reg.rx_tick))
      else $error("receiver stepped without receive clock edge");
   AST_RX_IRQ: assert property ((!s_reg.fifo_en && s_reg.ien[IEN_RX] &&
      s_reg.rx_cnt != 5'h00) |=> irq_out)
      else $error("rx interrupt missing in character mode");
   AST_RX_CLR: assert property ((!s_reg.fifo_en && rd_data &&
      s_reg.rx_cnt == 5'h01 && !rx_push && !s_reg.ien[IEN_TX] && !reg_wr)
      |=> s_reg.rx_cnt == 5'h00 ##1 !irq_out)
      else $error("rx interrupt not cleared by read");
   AST_SCRATCH: assert property ((reg_wr && reg_addr == OFS_SCR) ##1
      (reg_rd && reg_addr == OFS_SCR && !reg_wr) |=>
      reg_rdata == $past(reg_wdata, 2))
      else $error("scratch read back differs");
   AST_CHAR_DEPTH: assert property (!s_reg.fifo_en |->
      s_reg.rx_cnt <= CHAR_DEPTH && s_reg.tx_cnt <= CHAR_DEPTH)
      else $error("character mode holds more than one byte");
   AST_TX_BAUD: assert property (!bif.tick |=>
      s_reg.tx_tick == $past(s_reg.tx_tick))
      else $error("transmitter stepped without baud tick");
   AST_TX_IDLE: assert property ((s_reg.tx_st != TX_IDLE &&
      !(reg_wr && reg_addr == OFS_FCTL)) |=>
      s_reg.tx_rp == $past(s_reg.tx_rp))
      else $error("holding buffer popped while shifting");
   AST_TX_PIN: assert property ((s_reg.tx_st == TX_START |-> !serial_out) and
      (s_reg.tx_st == TX_DATA |-> serial_out == s_reg.tx_shift_reg[0]))
      else $error("serial output does not follow shift register");
   AST_TX_HOLDING_EMPTY_IRQ: assert property ((!s_reg.fifo_en && s_reg.ien[IEN_TX] &&
      s_reg.tx_cnt == 5'h00) |=> irq_out)
      else $error("holding-empty interrupt missing");
   AST_TX_HOLDING_EMPTY_CLR: assert property ((!s_reg.fifo_en && wr_data &&
      s_reg.tx_cnt == 5'h00) |=> s_reg.tx_cnt == 5'h01)
      else $error("holding write did not fill holding register");
   AST_FRAME: assert property (s_reg.tx_st == TX_DATA |->
      s_reg.tx_bit <= char_last(s_reg.lctl))
      else $error("transmit data bits exceed character length");

   COV_RX_PUSH: cover property (rx_push && s_reg.rx_cnt == 5'h00);
   COV_TX_FRAME: cover property (s_reg.tx_st == TX_STOP ##1
      s_reg.tx_st == TX_IDLE);
   COV_RX_FULL: cover property (s_reg.fifo_en && s_reg.rx_cnt == FIFO_DEPTH);

endmodule // uap_top

// ### uap_top_bench.sv
// Self-checking bench of the serial path: registers, tx line, rx path.
// Assumes uap_pkg, uap_top and uap_line_peer are compiled first.
`timescale 1ns/1ps
module uap_top_bench;
   import uap_pkg::*;
   logic ref_clk, rst_b, reg_wr, reg_rd, rx_clk_in, serial_in;
   logic serial_out, baud_tick_out, irq_out;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, rd_val;
   int errors, checked, cyc;

   uap_top dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .rx_clk_in(rx_clk_in), .serial_in(serial_in),
      .serial_out(serial_out), .baud_tick_out(baud_tick_out),
      .irq_out(irq_out));
   uap_line_peer peer (.rx_clk_in(rx_clk_in), .serial_in(serial_in));

   // ---------------------------------------------------------------
   // Clock, timeout and shared tasks
   // ---------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // Whole run needs about 8000 cycles
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         errors++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [2:0] a);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 rd_val = reg_rdata;
   endtask

   task automatic wait_irq(input logic lvl);
      for (int n = 0; n < 3000 && irq_out !== lvl; n++) @(posedge ref_clk);
      chk({7'h00, irq_out}, {7'h00, lvl});
   endtask

   // Divisor 2 gives 32 cycles per bit; samples at bit centres
   task automatic decode(input logic [7:0] d);
      for (int n = 0; n < 3000 && serial_out !== 1'b0; n++)
         @(posedge ref_clk);
      repeat (16) @(posedge ref_clk);
      chk({7'h00, serial_out}, 8'h00);
      for (int i = 0; i < 8; i++) begin
         repeat (32) @(posedge ref_clk);
         chk({7'h00, serial_out}, {7'h00, d[i]});
      end
      repeat (32) @(posedge ref_clk);
      chk({7'h00, serial_out}, 8'h01);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_scratch();
      wr(OFS_SCR, 8'h5A);
      rd(OFS_SCR);
      chk(rd_val, 8'h5A);
      wr(OFS_SCR, 8'hA5);
      rd(OFS_STAT);
      chk(rd_val, 8'h06);
      rd(OFS_SCR);
      chk(rd_val, 8'hA5);
      // Write then read with no gap between the strobes
      @(posedge ref_clk);
      reg_addr <= OFS_SCR;
      reg_wdata <= 8'h3C;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, 8'h3C);
   endtask

   // The first tick after a reload may come late, so skip two
   task automatic t_baud();
      int n;
      for (int dv = 3; dv > 1; dv--) begin
         wr(OFS_DIVL, 8'(dv));
         wr(OFS_DIVH, 8'h00);
         repeat (2) @(posedge baud_tick_out);
         n = 0;
         do begin
            @(posedge ref_clk);
            #1 n++;
         end while (baud_tick_out !== 1'b1 && n < 100);
         chk(8'(n), 8'(dv));
      end
   endtask

   // Second byte waits in holding; third is dropped in character mode
   task automatic t_tx();
      wr(OFS_IEN, 8'h02);
      wait_irq(1'b1);
      fork
         begin
            decode(8'h35);
            decode(8'h6C);
         end
         begin
            wr(OFS_DATA, 8'h35);
            repeat (8) @(posedge ref_clk);
            wr(OFS_DATA, 8'h6C);
            wr(OFS_DATA, 8'hFF);
            repeat (3) @(posedge ref_clk);
            chk({7'h00, irq_out}, 8'h00);
         end
      join
      for (int n = 0; n < 400; n++) begin
         @(posedge ref_clk);
         if (serial_out !== 1'b1) n = 400;
      end
      chk({7'h00, serial_out}, 8'h01);
   endtask

   // 7 data bits with even parity: 8'h07 goes out as 8'h87
   task automatic t_frame();
      wr(OFS_LCTL, 8'h1A);
      fork
         decode(8'h87);
         wr(OFS_DATA, 8'h07);
      join
      wr(OFS_LCTL, LCTL_RESET);
   endtask

   task automatic t_rx();
      wr(OFS_IEN, 8'h01);
      peer.send_char(8'hC3);
      wait_irq(1'b1);
      rd(OFS_DATA);
      chk(rd_val, 8'hC3);
      wait_irq(1'b0);
   endtask

   // Trigger level 4: no interrupt at three characters
   task automatic t_fifo();
      logic [7:0] q[4] = '{8'h11, 8'h82, 8'h4D, 8'hF0};
      wr(OFS_FCTL, 8'h41);
      for (int i = 0; i < 3; i++) peer.send_char(q[i]);
      repeat (20) @(posedge ref_clk);
      chk({7'h00, irq_out}, 8'h00);
      peer.send_char(q[3]);
      wait_irq(1'b1);
      foreach (q[i]) begin
         rd(OFS_DATA);
         chk(rd_val, q[i]);
      end
   endtask

   task automatic tally_and_finish();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      rst_b = 1'b0;
      errors = 0;
      checked = 0;
      cyc = 0;
      repeat (4) @(posedge ref_clk);
      rst_b <= 1'b1;
      t_scratch();
      t_baud();
      t_tx();
      t_frame();
      t_rx();
      t_fifo();
      tally_and_finish();
   end
endmodule // uap_top_bench
